// ===== core/block_encrypt_defs.svh
`ifndef BLOCK_ENCRYPT_DEFS_SVH
`define BLOCK_ENCRYPT_DEFS_SVH

// Register byte offsets.
`define OFS_BEGIN_TASK        12'h000
`define OFS_ABORT_TASK        12'h004
`define OFS_DONE_EVENT        12'h100
`define OFS_ABORT_EVENT       12'h104
`define OFS_IRQ_ENABLE_SET    12'h304
`define OFS_IRQ_ENABLE_CLEAR  12'h308
`define OFS_STRUCTURE_POINTER 12'h504

// Field positions.
`define BIT_EVENT             0
`define BIT_EN_DONE           0
`define BIT_EN_ABORT          1

// Reset values.
`define RST_POINTER           32'h0000_0000
`define RST_ENABLE            2'h0

// Data structure offsets in bytes and block length in words.
`define STRUCT_KEY_OFS        32'h0000_0000
`define STRUCT_CLEAR_OFS      32'h0000_0010
`define STRUCT_CIPHER_OFS     32'h0000_0020
`define STRUCT_WORDS          4'h4

// Block run time in ns and its cycle count at 10 ns.
`define RUN_TIME_NS           6000
`define CLK_PERIOD_NS         10
`define RUN_CYCLES            ((`RUN_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== core/block_encrypt_events.sv
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "block_encrypt_defs.svh"

// Overview of operation
// - Done event bit 0 sets when ciphertext is stored; software reads and writes it.
// - Abort event bit 0 sets when encryption ends early by abort or error.
// - Writing 1 to enable-set bit 0 enables done interrupt; reads show enable.
// - Writing 1 to enable-set bit 1 enables abort interrupt; reads show enable.
// - Writing 1 to enable-clear bit 0 disables done interrupt; reads show enable.
// - Writing 1 to enable-clear bit 1 disables abort interrupt; reads show enable.
// - Structure pointer is a 32-bit read-write register reset to zero.
// - One sixteen-byte block takes about six microseconds to process.
// - Begin task loads key and cleartext by DMA, stores ciphertext, then signals done.
// - Key at offset 0, cleartext at 16, ciphertext at 32 in the structure.
// - Begin task while the shared core is busy raises abort instead of starting.
// - Abort task during a running encryption raises the abort event.
module block_encrypt_events (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Avalon-MM slave
  input  wire logic [11:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Shared AES core
  input  wire logic        core_busy_i,
  output logic             core_claim_o,
  output logic [127:0]     core_key_o,
  output logic [127:0]     core_text_o,
  input  wire logic [127:0] core_result_i,
  // DMA master to data RAM
  output logic             dma_req_o,
  output logic             dma_we_o,
  output logic [31:0]      dma_addr_o,
  output logic [31:0]      dma_wdata_o,
  input  wire logic        dma_ack_i,
  input  wire logic [31:0] dma_rdata_i,
  // Interrupt
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // Bus access
  // ----------------------------------------------------------------
  logic        access_done;
  logic        next_access_done;
  logic [31:0] next_readdata;
  logic        next_waitrequest;
  logic        wr;
  logic        rd;

  assign wr = avs_write_i && !access_done && avs_byteenable_i[0];
  assign rd = avs_read_i && !access_done;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] structure_pointer;
  logic [31:0] next_structure_pointer;
  logic [1:0]  irq_enable;
  logic [1:0]  next_irq_enable;
  logic        done_flag;
  logic        abort_flag;
  logic        next_irq;
  block_encrypt_pkg::event_pair_s ev;

  logic begin_task;
  logic abort_task;
  logic full_word;

  assign full_word  = avs_byteenable_i == 4'hF;
  assign begin_task = wr && avs_address_i == `OFS_BEGIN_TASK && avs_writedata_i[0];
  assign abort_task = wr && avs_address_i == `OFS_ABORT_TASK && avs_writedata_i[0];

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  event_flag u_done_flag (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .set_i   (ev.done),
    .write_i (wr && avs_address_i == `OFS_DONE_EVENT),
    .wdata_i (avs_writedata_i[`BIT_EVENT]),
    .flag_o  (done_flag)
  );

  event_flag u_abort_flag (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .set_i   (ev.abort),
    .write_i (wr && avs_address_i == `OFS_ABORT_EVENT),
    .wdata_i (avs_writedata_i[`BIT_EVENT]),
    .flag_o  (abort_flag)
  );

  always_comb begin
    next_structure_pointer = structure_pointer;
    next_irq_enable        = irq_enable;
    // A partial write to the pointer is dropped so that its value stays whole.
    if (wr && full_word && avs_address_i == `OFS_STRUCTURE_POINTER) begin
      next_structure_pointer = avs_writedata_i;
    end
    // Enable-set and enable-clear sit at different addresses, so they never meet.
    if (wr && avs_address_i == `OFS_IRQ_ENABLE_SET) begin
      next_irq_enable = irq_enable | avs_writedata_i[1:0];
    end
    if (wr && avs_address_i == `OFS_IRQ_ENABLE_CLEAR) begin
      next_irq_enable = irq_enable & ~avs_writedata_i[1:0];
    end
    // The interrupt is a registered level, one cycle behind its flags.
    next_irq = (done_flag && irq_enable[`BIT_EN_DONE])
            || (abort_flag && irq_enable[`BIT_EN_ABORT]);
  end

  // ----------------------------------------------------------------
  // Read path and bus answer
  // ----------------------------------------------------------------
  always_comb begin
    // Waitrequest drops for one cycle after a request is taken; the flop blocks a repeat.
    next_access_done = (avs_read_i || avs_write_i) && !access_done;
    next_waitrequest = !next_access_done;
    next_readdata    = 32'h0000_0000;
    if (rd) begin
      unique case (avs_address_i)
        `OFS_DONE_EVENT:        next_readdata = {31'h0, done_flag};
        `OFS_ABORT_EVENT:       next_readdata = {31'h0, abort_flag};
        `OFS_IRQ_ENABLE_SET:    next_readdata = {30'h0, irq_enable};
        `OFS_IRQ_ENABLE_CLEAR:  next_readdata = {30'h0, irq_enable};
        `OFS_STRUCTURE_POINTER: next_readdata = structure_pointer;
        default:                next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      structure_pointer <= `RST_POINTER;
      irq_enable        <= `RST_ENABLE;
      access_done       <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
      irq_o             <= 1'b0;
    end else begin
      structure_pointer <= next_structure_pointer;
      irq_enable        <= next_irq_enable;
      access_done       <= next_access_done;
      avs_waitrequest_o <= next_waitrequest;
      avs_readdata_o    <= next_readdata;
      irq_o             <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Engine sequencer
  // ----------------------------------------------------------------
  block_encrypt_pkg::engine_state_e state;
  block_encrypt_pkg::engine_state_e next_state;
  logic [3:0]   word_idx;
  logic [3:0]   next_word_idx;
  logic [255:0] load_buf;
  logic [255:0] next_load_buf;
  logic [127:0] cipher;
  logic [127:0] next_cipher;
  block_encrypt_pkg::dma_req_s dma;
  block_encrypt_pkg::dma_req_s next_dma;
  logic         next_claim;
  logic         run_start;
  logic         run_expired;
  logic         next_done_ev;
  logic         next_abort_ev;
  logic         done_ev;
  logic         abort_ev;

  assign ev = '{done: done_ev, abort: abort_ev};

  // The timer stands in for the core's fixed processing time.
  run_timer u_run_timer (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .start_i   (run_start),
    .cancel_i  (abort_task),
    .expired_o (run_expired)
  );

  always_comb begin
    next_state    = state;
    next_word_idx = word_idx;
    next_load_buf = load_buf;
    next_cipher   = cipher;
    next_dma      = dma;
    next_claim    = core_claim_o;
    next_done_ev  = 1'b0;
    next_abort_ev = 1'b0;
    run_start     = 1'b0;
    unique case (state)
      block_encrypt_pkg::ST_IDLE: begin
        // A begin task that finds the core busy is refused and reported.
        if (begin_task && core_busy_i) begin
          next_abort_ev = 1'b1;
        end else if (begin_task) begin
          next_state    = block_encrypt_pkg::ST_LOAD;
          next_claim    = 1'b1;
          next_word_idx = 4'h0;
          next_dma      = '{req: 1'b1, we: 1'b0, addr: structure_pointer + `STRUCT_KEY_OFS,
                            wdata: 32'h0000_0000};
        end
      end
      block_encrypt_pkg::ST_LOAD: begin
        if (dma_ack_i) begin
          // Words arrive key first; the buffer shifts right so word 0 ends lowest.
          next_load_buf = {dma_rdata_i, load_buf[255:32]};
          next_word_idx = word_idx + 4'h1;
          next_dma.addr = dma.addr + 32'h0000_0004;
          if (word_idx == 4'h7) begin
            next_dma.req = 1'b0;
            next_state   = block_encrypt_pkg::ST_RUN;
            run_start    = 1'b1;
          end
        end
      end
      block_encrypt_pkg::ST_RUN: begin
        // The result is taken once the fixed run time has elapsed.
        if (run_expired) begin
          next_cipher   = core_result_i;
          next_state    = block_encrypt_pkg::ST_STORE;
          next_word_idx = 4'h0;
          next_dma      = '{req: 1'b1, we: 1'b1, addr: structure_pointer + `STRUCT_CIPHER_OFS,
                            wdata: core_result_i[31:0]};
        end
      end
      block_encrypt_pkg::ST_STORE: begin
        if (dma_ack_i) begin
          next_cipher    = {32'h0000_0000, cipher[127:32]};
          // The next word comes from the copy before it shifts.
          next_dma.wdata = cipher[63:32];
          next_dma.addr  = dma.addr + 32'h0000_0004;
          next_word_idx  = word_idx + 4'h1;
          if (word_idx == `STRUCT_WORDS - 4'h1) begin
            next_dma.req = 1'b0;
            next_state   = block_encrypt_pkg::ST_END;
          end
        end
      end
      block_encrypt_pkg::ST_END: begin
        // Short of an abort, the core is handed back only after the last word is written.
        next_done_ev = 1'b1;
        next_claim   = 1'b0;
        next_state   = block_encrypt_pkg::ST_IDLE;
      end
    endcase
    // Abort ends any active run; an outstanding DMA word is dropped.
    if (abort_task && state != block_encrypt_pkg::ST_IDLE) begin
      next_state    = block_encrypt_pkg::ST_IDLE;
      next_dma.req  = 1'b0;
      next_claim    = 1'b0;
      next_done_ev  = 1'b0;
      next_abort_ev = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state        <= block_encrypt_pkg::ST_IDLE;
      word_idx     <= 4'h0;
      load_buf     <= '0;
      cipher       <= '0;
      dma          <= '0;
      core_claim_o <= 1'b0;
      done_ev      <= 1'b0;
      abort_ev     <= 1'b0;
    end else begin
      state        <= next_state;
      word_idx     <= next_word_idx;
      load_buf     <= next_load_buf;
      cipher       <= next_cipher;
      dma          <= next_dma;
      core_claim_o <= next_claim;
      done_ev      <= next_done_ev;
      abort_ev     <= next_abort_ev;
    end
  end

  // ----------------------------------------------------------------
  // Engine outputs
  // ----------------------------------------------------------------
  always_comb begin
    dma_req_o   = dma.req;
    dma_we_o    = dma.we;
    dma_addr_o  = dma.addr;
    dma_wdata_o = dma.wdata;
    core_key_o  = load_buf[127:0];
    core_text_o = load_buf[255:128];
  end

endmodule : block_encrypt_events

`default_nettype wire

// ===== core/block_encrypt_pkg.sv
package block_encrypt_pkg;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dma_req_s;

  typedef struct packed {
    logic        done;
    logic        abort;
  } event_pair_s;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_LOAD  = 5'b00010,
    ST_RUN   = 5'b00100,
    ST_STORE = 5'b01000,
    ST_END   = 5'b10000
  } engine_state_e;

endpackage : block_encrypt_pkg

// ===== core/event_flag.sv
`timescale 1ns/1ps
`default_nettype none

module event_flag (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // Control
  input  wire logic set_i,
  input  wire logic write_i,
  input  wire logic wdata_i,
  // State
  output logic      flag_o
);

  logic next_flag;

  // Hardware set wins over a software write in the same cycle.
  always_comb begin
    next_flag = flag_o;
    if (write_i) begin
      next_flag = wdata_i;
    end
    if (set_i) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= next_flag;
    end
  end

endmodule : event_flag

`default_nettype wire

// ===== core/run_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "block_encrypt_defs.svh"

module run_timer #(
  parameter int unsigned CYCLES = `RUN_CYCLES
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // Control
  input  wire logic start_i,
  input  wire logic cancel_i,
  // Status
  output logic      expired_o
);

  logic [15:0] count;
  logic [15:0] next_count;
  logic        next_expired;

  always_comb begin
    next_count   = count;
    next_expired = 1'b0;
    if (cancel_i) begin
      next_count = 16'h0000;
    end else if (start_i) begin
      next_count = 16'(CYCLES);
    end else if (count != 16'h0000) begin
      next_count = count - 16'h0001;
      next_expired = (count == 16'h0001);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count     <= 16'h0000;
      expired_o <= 1'b0;
    end else begin
      count     <= next_count;
      expired_o <= next_expired;
    end
  end

endmodule : run_timer

`default_nettype wire

// ===== testbench/aes_ram_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------
// Data memory.
// ------------
module aes_ram_model (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_b_i,
  // Memory port
  input  wire logic                        slow_i,
  input  wire block_encrypt_pkg::dma_req_s req_i,
  output logic                             ack_o,
  output logic [31:0]                      rdata_o
);
  logic [31:0] mem [64];
  logic [1:0]  lag;

  // Read data toggles outside an answer so a stale word is never taken.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_o   <= 1'b0;
      lag     <= 2'h0;
      rdata_o <= 32'h0;
    end else if (req_i.req && !ack_o && (lag == 2'h3 || !slow_i)) begin
      ack_o <= 1'b1;
      lag   <= 2'h0;
      if (req_i.we) mem[req_i.addr[7:2]] <= req_i.wdata;
      else rdata_o <= mem[req_i.addr[7:2]];
    end else begin
      ack_o   <= 1'b0;
      lag     <= (req_i.req && !ack_o) ? lag + 2'h1 : 2'h0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule : aes_ram_model
`default_nettype wire

// ===== testbench/block_encrypt_events_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ------------
// Port checks.
// ------------
module block_encrypt_events_monitor (
  // Clock, reset and register bus
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic [11:0] avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // Core, memory and interrupt
  input wire logic        core_busy_i,
  input wire logic        core_claim_o,
  input wire logic        dma_req_o,
  input wire logic        dma_we_o,
  input wire logic [31:0] dma_addr_o,
  input wire logic        dma_ack_i,
  input wire logic        irq_o
);
  logic [9:0] run_cnt;
  logic       wr_end;

  assign wr_end = avs_write_i && !avs_waitrequest_o;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // Cycles since the engine took the core.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) run_cnt <= 10'h000;
    else if (!core_claim_o) run_cnt <= 10'h000;
    else if (run_cnt != 10'h3FF) run_cnt <= run_cnt + 10'h001;
  end

  a_wait_answer: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("late bus answer");
  a_event_width: assert property (
    avs_read_i && !avs_waitrequest_o && avs_address_i[11:3] == 9'h020
    |-> avs_readdata_o[31:1] == 31'h0) else $error("event upper bits set");
  a_busy_refused: assert property (
    wr_end && avs_address_i == 12'h000 && avs_writedata_i[0] && core_busy_i && !core_claim_o
    |=> (!core_claim_o && !dma_req_o) [*3]) else $error("started on busy core");
  a_abort_stops: assert property (
    wr_end && avs_address_i == 12'h004 && avs_writedata_i[0] |-> ##[1:3] !core_claim_o)
    else $error("abort ignored");
  a_dma_hold: assert property (
    dma_req_o && !dma_ack_i
    |=> !core_claim_o || (dma_req_o && $stable(dma_addr_o) && $stable(dma_we_o)))
    else $error("dma request dropped");
  a_dma_claimed: assert property (dma_req_o |-> core_claim_o)
    else $error("dma without core");
  a_run_length: assert property (dma_req_o && dma_we_o |-> run_cnt >= 10'h258)
    else $error("result stored early");
  a_irq_masked: assert property (
    wr_end && avs_address_i == 12'h308 && avs_writedata_i[1:0] == 2'h3 |-> ##[1:3] !irq_o)
    else $error("masked interrupt stays up");

  c_store: cover property (dma_req_o && dma_we_o && dma_ack_i);
  c_refused: cover property (wr_end && avs_address_i == 12'h000 && core_busy_i);
  c_irq: cover property ($rose(irq_o));
endmodule : block_encrypt_events_monitor

bind block_encrypt_events block_encrypt_events_monitor u_block_encrypt_events_monitor (
  .clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_readdata_o, .avs_waitrequest_o, .core_busy_i, .core_claim_o, .dma_req_o,
  .dma_we_o, .dma_addr_o, .dma_ack_i, .irq_o);
`default_nettype wire

// ===== testbench/block_encrypt_events_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// Bench.
// ------
module block_encrypt_events_tb_top;
  logic                        clk_i, rst_b_i, rd, wr, wreq, busy, slow, claim, irq;
  logic                        dreq, dwe, dack;
  logic [3:0]                  be;
  logic [11:0]                 adr;
  logic [31:0]                 wd, rdat, daddr, dwd, drd, q;
  logic [127:0]                key, text, res, ckey, ctext;
  int                          fails, checked;
  block_encrypt_pkg::dma_req_s dma;

  assign dma = {dreq, dwe, daddr, dwd};

  block_encrypt_events u_block_encrypt_events (
    .clk_i, .rst_b_i, .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .core_busy_i(busy), .core_claim_o(claim),
    .core_key_o(ckey), .core_text_o(ctext), .core_result_i(res), .dma_req_o(dreq),
    .dma_we_o(dwe), .dma_addr_o(daddr), .dma_wdata_o(dwd), .dma_ack_i(dack),
    .dma_rdata_i(drd), .irq_o(irq));
  aes_ram_model u_aes_ram_model (
    .clk_i, .rst_b_i, .slow_i(slow), .req_i(dma), .ack_o(dack), .rdata_o(drd));

  task automatic end_of_test;
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %0h want %0h", $time, got, exp);
    end
  endtask : chk

  task automatic bail;
    fails++;
    $display("FAIL %0t wait ran out", $time);
    end_of_test();
  endtask : bail

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] b = 4'hF);
    int n;
    n = 0;
    adr <= a;
    wd  <= d;
    be  <= b;
    wr  <= w;
    rd  <= !w;
    do begin
      @(posedge clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (wreq !== 1'b0) bail();
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rchk

  task automatic wait_set(input logic [11:0] a);
    repeat (400) begin
      bus(1'b0, a, 32'h0);
      if (q[0] === 1'b1) return;
    end
    bail();
  endtask : wait_set

  task automatic t_regs;
    logic [11:0] a [6] = '{12'h304, 12'h304, 12'h308, 12'h308, 12'h304, 12'h308};
    logic [31:0] d [6] = '{32'h1, 32'h2, 32'h0, 32'h1, 32'h0, 32'h2};
    logic [31:0] e [6] = '{32'h1, 32'h3, 32'h3, 32'h2, 32'h2, 32'h0};
    rchk(12'h100, 32'h0);
    rchk(12'h104, 32'h0);
    rchk(12'h308, 32'h0);
    rchk(12'h504, 32'h0);
    bus(1'b1, 12'h010, 32'hFFFF_FFFF);
    rchk(12'h010, 32'h0);
    bus(1'b1, 12'h504, 32'hA5C3_0F04);
    bus(1'b1, 12'h504, 32'h0000_0040, 4'h3);
    rchk(12'h504, 32'hA5C3_0F04);
    bus(1'b1, 12'h504, 32'h0000_0040);
    foreach (a[i]) begin
      bus(1'b1, a[i], d[i]);
      rchk(12'h304, e[i]);
      rchk(12'h308, e[i]);
    end
  endtask : t_regs

  task automatic t_encrypt(input logic s);
    slow <= s;
    res  <= {4{s, 31'h1234_5678}} ^ 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0;
    for (int i = 0; i < 4; i++) begin
      key[32*i +: 32]  = 32'h1000_0000 + i;
      text[32*i +: 32] = 32'h2000_0000 + i;
      u_aes_ram_model.mem[16+i] = key[32*i +: 32];
      u_aes_ram_model.mem[20+i] = text[32*i +: 32];
    end
    bus(1'b1, 12'h304, 32'h1);
    bus(1'b1, 12'h000, 32'h1);
    wait_set(12'h100);
    chk(ckey, key);
    chk(ctext, text);
    for (int i = 0; i < 4; i++) chk(u_aes_ram_model.mem[24+i], res[32*i +: 32]);
    rchk(12'h104, 32'h0);
    chk(irq, 1'b1);
    bus(1'b1, 12'h100, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    rchk(12'h100, 32'h0);
    bus(1'b1, 12'h308, 32'h1);
  endtask : t_encrypt

  task automatic t_busy;
    busy <= 1'b1;
    bus(1'b1, 12'h304, 32'h2);
    bus(1'b1, 12'h000, 32'h1);
    busy <= 1'b0;
    chk(claim, 1'b0);
    rchk(12'h104, 32'h1);
    rchk(12'h100, 32'h0);
    chk(irq, 1'b1);
    bus(1'b1, 12'h308, 32'h3);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    bus(1'b1, 12'h104, 32'h0);
    rchk(12'h104, 32'h0);
  endtask : t_busy

  task automatic t_abort;
    bus(1'b1, 12'h000, 32'h1);
    repeat (200) @(posedge clk_i);
    chk(claim, 1'b1);
    bus(1'b1, 12'h004, 32'h1);
    chk(claim, 1'b0);
    rchk(12'h104, 32'h1);
    repeat (700) @(posedge clk_i);
    rchk(12'h100, 32'h0);
  endtask : t_abort

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    {rst_b_i, rd, wr, busy, slow, adr, wd, be, res} = '0;
    fails   = 0;
    checked = 0;
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    t_regs();
    t_encrypt(1'b0);
    t_encrypt(1'b1);
    t_busy();
    t_abort();
    end_of_test();
  end
endmodule : block_encrypt_events_tb_top
`default_nettype wire
